// file: bench/sep_bench.sv
// bench: host and device joined over the serial link, driven through axi4-lite
`timescale 1ns/10ps
module sep_bench;
  logic        clk = 1'b0, rst_b = 1'b0, busy, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic        aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
  logic [5:0]  aw_a = 6'h00, ar_a = 6'h00;
  logic [31:0] w_d = 32'h0, r_d, q, m;
  logic [7:0]  status;
  logic [91:0] r;
  int          err_count = 0, n_checks = 0;
  // rows: control (bit 15 skips idle wait), address, data sent, expected receive
  logic [91:0] rows [32] = '{
    {16'h0405, 12'h0, 32'h0, 32'h60}, {16'h0006, 12'h0, 32'h0, 32'h0},
    {16'h0405, 12'h0, 32'h0, 32'h62}, {16'h1202, 12'h7FE, 32'h11223344, 32'h0},
    {16'h8405, 12'h0, 32'h0, 32'hFF}, {16'h0405, 12'h0, 32'h0, 32'h60},
    {16'h0006, 12'h0, 32'h0, 32'h0}, {16'h0A02, 12'h0, 32'h55665566, 32'h0},
    {16'h1203, 12'h7FE, 32'h0, 32'h11225566}, {16'h0006, 12'h0, 32'h0, 32'h0},
    {16'h0004, 12'h0, 32'h0, 32'h0}, {16'h0602, 12'h0, 32'hAAAAAAAA, 32'h0},
    {16'h0603, 12'h0, 32'h0, 32'h55}, {16'h0006, 12'h0, 32'h0, 32'h0},
    {16'h0401, 12'h0, 32'h98989898, 32'h0}, {16'h0405, 12'h0, 32'h0, 32'hF8},
    {16'h0006, 12'h0, 32'h0, 32'h0}, {16'h0602, 12'h1, 32'h77777777, 32'h0},
    {16'h0602, 12'h20, 32'h99999999, 32'h0}, {16'h0A03, 12'h0, 32'h0, 32'h5566},
    {16'h0603, 12'h20, 32'h0, 32'h99}, {16'h0006, 12'h0, 32'h0, 32'h0},
    {16'h4401, 12'h0, 32'h0, 32'h0}, {16'h4405, 12'h0, 32'h0, 32'hFA},
    {16'h0401, 12'h0, 32'h0, 32'h0}, {16'h0405, 12'h0, 32'h0, 32'h60},
    {16'h0006, 12'h0, 32'h0, 32'h0}, {16'h0401, 12'h0, 32'h1C1C1C1C, 32'h0},
    {16'h0006, 12'h0, 32'h0, 32'h0}, {16'h0405, 12'h0, 32'h0, 32'h7E},
    {16'h0602, 12'h7E0, 32'hCCCCCCCC, 32'h0}, {16'h0603, 12'h7E0, 32'h0, 32'h33}};

  ////////////////////////////////////////////////////////////////////////////
  // link, both ends and the checker
  sep_spi_if sep_spi_if_i ();
  sep_dev #(.WC_CYCLES(2000)) sep_dev_i (.SYS_CLK_IN(clk), .RST_B_IN(rst_b),
    .SPI(sep_spi_if_i.dev), .STATUS_OUT(status), .BUSY_OUT(busy));
  sep_host sep_host_i (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .SPI(sep_spi_if_i.host),
    .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy), .S_AXI_AWADDR(aw_a), .S_AXI_WVALID(w_v),
    .S_AXI_WREADY(w_rdy), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(b_v),
    .S_AXI_BREADY(b_rdy), .S_AXI_BRESP(), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy),
    .S_AXI_ARADDR(ar_a), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_rdy), .S_AXI_RDATA(r_d),
    .S_AXI_RRESP());
  sep_chk sep_chk_i (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .cs_b(sep_spi_if_i.cs_b),
    .so(sep_spi_if_i.so), .so_oe_b(sep_spi_if_i.so_oe_b), .hold_b(sep_spi_if_i.hold_b),
    .STATUS_OUT(status), .BUSY_OUT(busy));

  ////////////////////////////////////////////////////////////////////////////
  // verdict, compare, wait limit
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic limit(input int k, input int lim);
    if (k >= lim) begin
      err_count++;
      finish_test();
    end
  endtask : limit

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite master: hold each channel until its own handshake edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    aw_v <= 1'b1; w_v <= 1'b1; b_rdy <= 1'b1; aw_a <= a; w_d <= d;
    do begin
      @(posedge clk);
      k++;
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
    end while (b_v !== 1'b1 && k < 50);
    b_rdy <= 1'b0;
    // one edge between transfers so no signal is set twice in a step
    @(posedge clk);
    limit(k, 50);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    int k;
    k = 0;
    ar_v <= 1'b1; r_rdy <= 1'b1; ar_a <= a;
    do begin
      @(posedge clk);
      k++;
      if (ar_rdy) ar_v <= 1'b0;
    end while (r_v !== 1'b1 && k < 50);
    d = r_d;
    r_rdy <= 1'b0;
    @(posedge clk);
    limit(k, 50);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // start one serial sequence, then wait for done and compare received bytes
  task automatic go(input logic [15:0] c, input logic [11:0] a, input logic [31:0] t);
    wr(sep_pkg::HR_CTRL, {17'h0, c[14:0]});
    wr(sep_pkg::HR_ADDR, {20'h0, a});
    wr(sep_pkg::HR_TXD, t);
    wr(sep_pkg::HR_GO, 32'h0);
  endtask : go
  task automatic fin(input logic [15:0] c, input logic [31:0] e);
    int k;
    k = 0;
    do begin
      rd(sep_pkg::HR_STAT, q);
      k++;
    end while (q[1] !== 1'b1 && k < 2000);
    limit(k, 2000);
    if (e != 32'h0) begin
      rd(sep_pkg::HR_RXD, q);
      m = (c[12:10] > 3'h3) ? 32'hFFFFFFFF : ~(32'hFFFFFFFF << (8 * c[12:10]));
      chk(q & m, e);
    end
  endtask : fin
  task automatic idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    limit(k, 5000);
  endtask : idle

  ////////////////////////////////////////////////////////////////////////////
  // clock, reset, row loop, pause and second reset
  always #2 clk = ~clk;
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (rows[i]) begin
      r = rows[i];
      if (!r[91]) idle();
      go(r[91:76], r[75:64], r[63:32]);
      fin(r[91:76], r[31:0]);
      $display("row %0d done", i);
    end
    idle();
    go(16'h0A03, 12'h0, 32'h0);
    // pause lands in the data bytes, while the device drives its output
    repeat (850) @(posedge clk);
    wr(sep_pkg::HR_CTRL, 32'h00002A03);
    repeat (600) @(posedge clk);
    wr(sep_pkg::HR_CTRL, 32'h00000A03);
    fin(16'h0A03, 32'h5566);
    $display("pause test done");
    go(16'h0006, 12'h0, 32'h0);
    fin(16'h0006, 32'h0);
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    go(16'h0405, 12'h0, 32'h0);
    fin(16'h0405, 32'h60);
    $display("reset test done");
    finish_test();
  end
endmodule : sep_bench

// file: bench/sep_chk.sv
// checker on the serial link and the device status outputs
`timescale 1ns/10ps
module sep_chk (
  input wire logic       SYS_CLK_IN,
  input wire logic       RST_B_IN,
  input wire logic       cs_b,
  input wire logic       so,
  input wire logic       so_oe_b,
  input wire logic       hold_b,
  input wire logic [7:0] STATUS_OUT,
  input wire logic       BUSY_OUT
);
  // one clock domain, reset disables all checks
  default clocking dc @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  ////////////////////////////////////////////////////////////////////////////
  // output released within a few clocks of its cause
  sequence s_released;
    ##[0:6] so_oe_b;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // link release, status layout, latch and protect-bit timing
  property p_cs_release; $rose(cs_b) |-> s_released; endproperty
  a_cs_release: assert property (p_cs_release) else $error("output held after deselect");
  property p_hold_release; $fell(hold_b) |-> s_released; endproperty
  a_hold_release: assert property (p_hold_release) else $error("output held in pause");
  property p_fixed_ones; STATUS_OUT[6:5] == 2'h3; endproperty
  a_fixed_ones: assert property (p_fixed_ones) else $error("status fixed bits wrong");
  // busy shown in status, and a cycle only starts once deselected
  property p_busy_bit;
    STATUS_OUT[0] == BUSY_OUT && (!$rose(BUSY_OUT) || cs_b);
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("busy bit or busy start wrong");
  property p_busy_high; BUSY_OUT && !cs_b && !so_oe_b |-> so; endproperty
  a_busy_high: assert property (p_busy_high) else $error("output low while busy");
  property p_latch_end; $fell(BUSY_OUT) |-> ##[0:1] !STATUS_OUT[1]; endproperty
  a_latch_end: assert property (p_latch_end) else $error("latch kept after cycle");
  property p_latch_set; $rose(STATUS_OUT[1]) |-> !cs_b && !BUSY_OUT; endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch set outside command");
  property p_prot_change; $changed(STATUS_OUT[7:2]) |-> $fell(BUSY_OUT); endproperty
  a_prot_change: assert property (p_prot_change) else $error("protect bits moved early");
endmodule : sep_chk

// file: core/sep_dev.sv
// serial eeprom device: protection, latch, status, pause and sequential read
`timescale 1ns/10ps
module sep_dev #(
  parameter int ADDR_W     = 11,
  parameter int ADDR_BYTES = 2,
  parameter int PAGE_W     = 5,
  parameter bit A8_IN_OP   = 1'b0,
  parameter int WC_CYCLES  = sep_pkg::WC_CYCLES
) (
  input  wire logic       SYS_CLK_IN,
  input  wire logic       RST_B_IN,
  sep_spi_if.dev          SPI,
  output wire logic [7:0] STATUS_OUT,
  output wire logic       BUSY_OUT
);

  localparam int WC_W = $clog2(WC_CYCLES + 1);

  typedef struct packed {
    logic [1:0]          sck_s;
    logic [1:0]          cs_s;
    logic [1:0]          si_s;
    logic [1:0]          hold_s;
    logic [1:0]          wp_s;
    logic                sck_d;
    logic                cs_d;
    sep_pkg::sep_dphase_t ph;
    logic [2:0]          bit_c;
    logic [1:0]          ab_c;
    logic [7:0]          sh_in;
    logic [7:0]          sh_out;
    logic [7:0]          op;
    logic                rd;
    logic                drv;
    logic [ADDR_W-1:0]   addr;
    logic                wl;
    logic                busy;
    logic                wr_pend;
    logic                st_pend;
    logic [7:0]          st_val;
    logic                hpe;
    logic [2:0]          bp;
    logic [WC_W-1:0]     wc;
    logic                so;
    logic                so_oe_b;
  } sep_dev_state_t;

  sep_dev_state_t    s_r;
  sep_dev_state_t    s_nxt;
  logic [7:0]        mem [0:(2**ADDR_W)-1];
  logic              mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]        mem_wd;

  ////////////////////////////////////////////////////////////////////////////
  // region test for the protect code
  function automatic logic prot_hit(input logic [2:0] bp, input logic [ADDR_W-1:0] a);
    logic [1:0] q;
    q = a[ADDR_W-1 -: 2];
    case (bp)
      sep_pkg::BP_NONE:  prot_hit = 1'b0;
      sep_pkg::BP_HALF:  prot_hit = ~a[ADDR_W-1];
      sep_pkg::BP_FIRST: prot_hit = (a[ADDR_W-1:PAGE_W] == '0);
      sep_pkg::BP_LAST:  prot_hit = (&a[ADDR_W-1:PAGE_W]);
      default:           prot_hit = (q == 2'(bp - 3'h1));
    endcase
  endfunction : prot_hit

  ////////////////////////////////////////////////////////////////////////////
  // status byte as read back
  function automatic logic [7:0] stat_byte(input sep_dev_state_t s);
    stat_byte = {s.hpe, sep_pkg::SR_ONES, s.bp, s.wl, s.busy};
  endfunction : stat_byte

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic              hw_prot;
    logic              rise;
    logic              fall;
    logic              st_ok;
    logic [7:0]        b;
    logic [ADDR_W-1:0] na;
    s_nxt   = s_r;
    mem_we  = 1'b0;
    mem_wa  = s_r.addr;
    mem_wd  = 8'h00;
    b       = {s_r.sh_in[6:0], s_r.si_s[1]};
    na      = s_r.addr;
    st_ok   = 1'b0;
    hw_prot = s_r.hpe & ~s_r.wp_s[1];
    rise    = s_r.sck_s[1] & ~s_r.sck_d;
    fall    = ~s_r.sck_s[1] & s_r.sck_d;
    // two-stage synchronisers
    s_nxt.sck_s  = {s_r.sck_s[0], SPI.sck};
    s_nxt.cs_s   = {s_r.cs_s[0], SPI.cs_b};
    s_nxt.si_s   = {s_r.si_s[0], SPI.si};
    s_nxt.hold_s = {s_r.hold_s[0], SPI.hold_b};
    s_nxt.wp_s   = {s_r.wp_s[0], SPI.wp_b};
    s_nxt.sck_d  = s_r.sck_s[1];
    s_nxt.cs_d   = s_r.cs_s[1];
    // internal write cycle countdown
    if (s_r.busy) begin
      if (s_r.wc == '0) begin
        s_nxt.busy = 1'b0;
        s_nxt.wl   = 1'b0;
        if (s_r.st_pend) begin
          s_nxt.hpe     = s_r.st_val[sep_pkg::SR_HPE_POS];
          s_nxt.bp      = s_r.st_val[sep_pkg::SR_BP_LSB +: 3];
          s_nxt.st_pend = 1'b0;
        end
      end else begin
        s_nxt.wc = s_r.wc - 1'b1;
      end
    end
    if (s_r.cs_s[1]) begin
      // deselected: sequence ends, output released
      s_nxt.ph    = sep_pkg::DP_CMD;
      s_nxt.bit_c = 3'h0;
      s_nxt.ab_c  = 2'h0;
      s_nxt.drv   = 1'b0;
      if (!s_r.cs_d) begin
        st_ok = s_r.st_pend & s_r.wl & ~hw_prot;
        if (!s_r.busy && (s_r.wr_pend || st_ok)) begin
          s_nxt.busy = 1'b1;
          s_nxt.wc   = WC_W'(WC_CYCLES - 1);
        end
        s_nxt.wr_pend = 1'b0;
        if (!st_ok || s_r.busy) begin
          s_nxt.st_pend = 1'b0;
        end
      end
    end else if (s_r.hold_s[1]) begin
      // pause low freezes all sequence state
      if (rise) begin
        s_nxt.sh_in = b;
        s_nxt.bit_c = s_r.bit_c + 3'h1;
        if (s_r.bit_c == 3'h7) begin
          case (s_r.ph)
            sep_pkg::DP_CMD: begin
              s_nxt.op = b;
              s_nxt.rd = 1'b0;
              s_nxt.ph = sep_pkg::DP_DEAD;
              if (s_r.busy) begin
                if (b == sep_pkg::OP_STATUS_READ) begin
                  s_nxt.ph     = sep_pkg::DP_DATA;
                  s_nxt.rd     = 1'b1;
                  s_nxt.sh_out = sep_pkg::SR_BUSY_RD;
                end
              end else if (b == sep_pkg::OP_LATCH_SET) begin
                s_nxt.wl = 1'b1;
              end else if (b == sep_pkg::OP_LATCH_CLEAR) begin
                s_nxt.wl = 1'b0;
              end else if (b == sep_pkg::OP_STATUS_READ) begin
                s_nxt.ph     = sep_pkg::DP_DATA;
                s_nxt.rd     = 1'b1;
                s_nxt.sh_out = stat_byte(s_r);
              end else if (b == sep_pkg::OP_STATUS_WRITE) begin
                s_nxt.ph = sep_pkg::DP_DATA;
              end else if ((b & ~(8'h01 << sep_pkg::OP_A8_POS)) == sep_pkg::OP_READ ||
                           (b & ~(8'h01 << sep_pkg::OP_A8_POS)) == sep_pkg::OP_WRITE) begin
                if (A8_IN_OP || !b[sep_pkg::OP_A8_POS]) begin
                  s_nxt.ph   = sep_pkg::DP_ADDR;
                  s_nxt.rd   = b[0];
                  s_nxt.addr = ADDR_W'({b[sep_pkg::OP_A8_POS] & A8_IN_OP, 8'h00});
                end
              end
            end
            sep_pkg::DP_ADDR: begin
              if (ADDR_BYTES == 1) begin
                na = s_r.addr | ADDR_W'(b);
              end else begin
                na = ADDR_W'({s_r.addr, b});
              end
              s_nxt.addr = na;
              s_nxt.ab_c = s_r.ab_c + 2'h1;
              if (s_r.ab_c == 2'(ADDR_BYTES - 1)) begin
                s_nxt.ph = sep_pkg::DP_DATA;
                if (s_r.rd) begin
                  s_nxt.sh_out = mem[na];
                  s_nxt.addr   = na + 1'b1;
                end
              end
            end
            sep_pkg::DP_DATA: begin
              if (s_r.op == sep_pkg::OP_STATUS_READ) begin
                s_nxt.sh_out = s_r.busy ? sep_pkg::SR_BUSY_RD : stat_byte(s_r);
              end else if (s_r.op == sep_pkg::OP_STATUS_WRITE) begin
                s_nxt.st_pend = 1'b1;
                s_nxt.st_val  = b;
                s_nxt.ph      = sep_pkg::DP_DEAD;
              end else if (s_r.rd) begin
                s_nxt.sh_out = mem[s_r.addr];
                s_nxt.addr   = s_r.addr + 1'b1;
              end else begin
                if (s_r.wl && !prot_hit(s_r.bp, s_r.addr)) begin
                  mem_we        = 1'b1;
                  mem_wd        = b;
                  s_nxt.wr_pend = 1'b1;
                end
                s_nxt.addr = {s_r.addr[ADDR_W-1:PAGE_W], s_r.addr[PAGE_W-1:0] + 1'b1};
              end
            end
            default: begin
              s_nxt.ph = sep_pkg::DP_DEAD;
            end
          endcase
        end
      end
      // shift out on the falling edge during read phases
      if (fall && s_r.ph == sep_pkg::DP_DATA && s_r.rd) begin
        s_nxt.so     = s_r.sh_out[7];
        s_nxt.sh_out = {s_r.sh_out[6:0], 1'b0};
        s_nxt.drv    = 1'b1;
      end
    end
    s_nxt.so_oe_b = ~(s_nxt.drv & s_r.hold_s[1] & ~s_r.cs_s[1]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; latch starts clear
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s_r         <= '0;
      s_r.cs_s    <= 2'h3;
      s_r.cs_d    <= 1'b1;
      s_r.hold_s  <= 2'h3;
      s_r.wp_s    <= 2'h3;
      s_r.so_oe_b <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array storage
  always_ff @(posedge SYS_CLK_IN) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign SPI.so      = s_r.so;
  assign SPI.so_oe_b = s_r.so_oe_b;
  assign STATUS_OUT  = stat_byte(s_r);
  assign BUSY_OUT    = s_r.busy;

endmodule : sep_dev

// file: core/sep_host.sv
// serial eeprom host: axi4-lite command registers driving the serial link
`timescale 1ns/10ps
module sep_host #(
  parameter int SCK_HALF = sep_pkg::SCK_HALF_CYC
) (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_B_IN,
  sep_spi_if.host          SPI,
  input  wire logic        S_AXI_AWVALID,
  output wire logic        S_AXI_AWREADY,
  input  wire logic [5:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output wire logic        S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output wire logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output wire logic [1:0]  S_AXI_BRESP,
  input  wire logic        S_AXI_ARVALID,
  output wire logic        S_AXI_ARREADY,
  input  wire logic [5:0]  S_AXI_ARADDR,
  output wire logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output wire logic [31:0] S_AXI_RDATA,
  output wire logic [1:0]  S_AXI_RRESP
);

  typedef struct packed {
    logic                 aw_got;
    logic [5:0]           aw_a;
    logic                 w_got;
    logic [31:0]          w_d;
    logic [3:0]           w_s;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [14:0]          ctrl;
    logic [15:0]          addr;
    logic [31:0]          txd;
    logic [31:0]          rxd;
    logic                 done;
    sep_pkg::sep_hstate_t hs;
    logic [7:0]           half;
    logic [5:0]           bits;
    logic [55:0]          tx;
    logic [1:0]           so_s;
    logic                 sck;
    logic                 cs_b;
    logic                 hold_b;
    logic                 wp_b;
  } sep_host_state_t;

  sep_host_state_t s_r;
  sep_host_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] m);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = m[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic        start;
    logic [1:0]  ab;
    logic [2:0]  db;
    logic [47:0] tail;
    s_nxt = s_r;
    start = 1'b0;
    tail  = 48'h0;
    ab    = s_r.ctrl[sep_pkg::CF_AB_LSB +: 2];
    db    = s_r.ctrl[sep_pkg::CF_DB_LSB +: 3];
    s_nxt.so_s = {s_r.so_s[0], SPI.so_line};
    // write channels, taken in either order
    if (S_AXI_AWVALID && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_a   = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_d   = S_AXI_WDATA;
      s_nxt.w_s   = S_AXI_WSTRB;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = sep_pkg::RESP_OK;
      case ({s_r.aw_a[5:2], 2'h0})
        sep_pkg::HR_CTRL: s_nxt.ctrl = 15'(merge(32'(s_r.ctrl), s_r.w_d, s_r.w_s));
        sep_pkg::HR_ADDR: s_nxt.addr = 16'(merge(32'(s_r.addr), s_r.w_d, s_r.w_s));
        sep_pkg::HR_TXD:  s_nxt.txd  = merge(s_r.txd, s_r.w_d, s_r.w_s);
        sep_pkg::HR_GO:   start      = (s_r.hs == sep_pkg::HS_IDLE);
        default:          s_nxt.bresp = sep_pkg::RESP_ERR;
      endcase
    end
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end
    // read channel
    if (S_AXI_ARVALID && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = sep_pkg::RESP_OK;
      case ({S_AXI_ARADDR[5:2], 2'h0})
        sep_pkg::HR_CTRL: s_nxt.rdata = 32'(s_r.ctrl);
        sep_pkg::HR_ADDR: s_nxt.rdata = 32'(s_r.addr);
        sep_pkg::HR_TXD:  s_nxt.rdata = s_r.txd;
        sep_pkg::HR_RXD:  s_nxt.rdata = s_r.rxd;
        sep_pkg::HR_STAT: s_nxt.rdata = {30'h0, s_r.done, s_r.hs != sep_pkg::HS_IDLE};
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = sep_pkg::RESP_ERR;
        end
      endcase
    end
    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
    // serial sequencer
    case (s_r.hs)
      sep_pkg::HS_IDLE: begin
        s_nxt.hold_b = ~s_r.ctrl[sep_pkg::CF_HOLD];
        if (start) begin
          case (ab)
            2'h1:    tail = {s_r.addr[7:0], s_r.txd, 8'h00};
            2'h2:    tail = {s_r.addr, s_r.txd};
            default: tail = {s_r.txd, 16'h0000};
          endcase
          s_nxt.tx   = {s_r.ctrl[7:0], tail};
          s_nxt.bits = 6'(8 * (1 + 32'(ab) + 32'(db)));
          s_nxt.cs_b = 1'b0;
          s_nxt.done = 1'b0;
          s_nxt.half = 8'(SCK_HALF - 1);
          s_nxt.hs   = sep_pkg::HS_LOW;
        end
      end
      sep_pkg::HS_LOW: begin
        s_nxt.hold_b = ~s_r.ctrl[sep_pkg::CF_HOLD];
        if (s_r.half != 8'h00) begin
          s_nxt.half = s_r.half - 8'h01;
        end else if (s_r.hold_b) begin
          s_nxt.sck  = 1'b1;
          s_nxt.half = 8'(SCK_HALF - 1);
          s_nxt.hs   = sep_pkg::HS_HIGH;
        end
      end
      sep_pkg::HS_HIGH: begin
        if (s_r.half != 8'h00) begin
          s_nxt.half = s_r.half - 8'h01;
        end else begin
          s_nxt.rxd  = {s_r.rxd[30:0], s_r.so_s[1]};
          s_nxt.sck  = 1'b0;
          s_nxt.tx   = {s_r.tx[54:0], 1'b0};
          s_nxt.bits = s_r.bits - 6'h01;
          s_nxt.half = 8'(SCK_HALF - 1);
          s_nxt.hs   = (s_r.bits == 6'h01) ? sep_pkg::HS_END : sep_pkg::HS_LOW;
        end
      end
      default: begin
        // chip select hold, then deselect time
        if (s_r.half != 8'h00) begin
          s_nxt.half = s_r.half - 8'h01;
        end else if (!s_r.cs_b) begin
          s_nxt.cs_b = 1'b1;
          s_nxt.half = 8'(SCK_HALF - 1);
        end else begin
          s_nxt.done = 1'b1;
          s_nxt.hs   = sep_pkg::HS_IDLE;
        end
      end
    endcase
    s_nxt.wp_b    = ~s_r.ctrl[sep_pkg::CF_WP];
    s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
    s_nxt.wready  = ~s_nxt.w_got & ~s_nxt.bvalid;
    s_nxt.arready = ~s_nxt.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s_r        <= '0;
      s_r.cs_b   <= 1'b1;
      s_r.hold_b <= 1'b1;
      s_r.wp_b   <= 1'b1;
      s_r.so_s   <= 2'h3;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign SPI.sck       = s_r.sck;
  assign SPI.cs_b      = s_r.cs_b;
  assign SPI.si        = s_r.tx[55];
  assign SPI.hold_b    = s_r.hold_b;
  assign SPI.wp_b      = s_r.wp_b;
  assign S_AXI_AWREADY = s_r.awready;
  assign S_AXI_WREADY  = s_r.wready;
  assign S_AXI_BVALID  = s_r.bvalid;
  assign S_AXI_BRESP   = s_r.bresp;
  assign S_AXI_ARREADY = s_r.arready;
  assign S_AXI_RVALID  = s_r.rvalid;
  assign S_AXI_RDATA   = s_r.rdata;
  assign S_AXI_RRESP   = s_r.rresp;

endmodule : sep_host

// file: core/sep_pkg.sv
// shared constants and types for the serial eeprom device and its host
package sep_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned T_WC_NS       = 5000000;                // write cycle
  localparam int unsigned WC_CYCLES     = T_WC_NS / CLK_PERIOD_NS;
  localparam int unsigned SCK_HALF_CYC  = 16;                     // host sck half

  ////////////////////////////////////////////////////////////////////////////
  // instruction codes
  localparam logic [7:0] OP_LATCH_SET    = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_WRITE        = 8'h02;
  localparam int         OP_A8_POS       = 3;

  ////////////////////////////////////////////////////////////////////////////
  // status register layout
  localparam int         SR_HPE_POS = 7;
  localparam int         SR_BP_LSB  = 2;
  localparam logic [1:0] SR_ONES    = 2'h3;
  localparam logic [2:0] BP_NONE    = 3'h0;
  localparam logic [2:0] BP_HALF    = 3'h5;
  localparam logic [2:0] BP_FIRST   = 3'h6;
  localparam logic [2:0] BP_LAST    = 3'h7;
  localparam logic [7:0] SR_BUSY_RD = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // host registers and control fields
  localparam logic [5:0] HR_CTRL  = 6'h00;
  localparam logic [5:0] HR_ADDR  = 6'h04;
  localparam logic [5:0] HR_TXD   = 6'h08;
  localparam logic [5:0] HR_RXD   = 6'h0C;
  localparam logic [5:0] HR_STAT  = 6'h10;
  localparam logic [5:0] HR_GO    = 6'h14;
  localparam int         CF_AB_LSB = 8;
  localparam int         CF_DB_LSB = 10;
  localparam int         CF_HOLD   = 13;
  localparam int         CF_WP     = 14;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // state encodings
  typedef enum logic [1:0] {
    DP_CMD  = 2'h0,
    DP_ADDR = 2'h1,
    DP_DATA = 2'h3,
    DP_DEAD = 2'h2
  } sep_dphase_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_LOW  = 2'h1,
    HS_HIGH = 2'h3,
    HS_END  = 2'h2
  } sep_hstate_t;

endpackage : sep_pkg

// file: core/sep_spi_if.sv
// serial link between eeprom device and host
`timescale 1ns/10ps
interface sep_spi_if;
  logic sck;
  logic cs_b;
  logic si;
  logic so;
  logic so_oe_b;
  logic hold_b;
  logic wp_b;
  logic so_line;

  // released output reads high
  assign so_line = so_oe_b ? 1'b1 : so;

  modport dev  (input sck, cs_b, si, hold_b, wp_b, output so, so_oe_b);
  modport host (output sck, cs_b, si, hold_b, wp_b, input so_line);
endinterface : sep_spi_if
